// [core/lane_ser_pkg.sv]
/*
  Package for the parallel-to-lane serializer: timing counts, frame
  layout, lane modes, states and the control struct.
  Assumes one system clock; the parallel strobe is a sampled input.
*/
// Operation
// - The input word is sampled on the strobe edge picked by edge select.
// - Power-down low disables the block, parks the lanes and stops the PLL.
// - Lane select low gives two lanes, high gives four lanes per word.
// - Self-test high replaces the payload with an internal test pattern.
// - Pre-emphasis is off when its select is high or floating.
// - Each 32-bit word goes out on the lanes with the clock embedded.
// - The payload is scrambled and balance coded before it is sent.
package lane_ser_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int WORD_W      = 32;
  localparam int LANE_MAX    = 4;
  localparam int FIFO_DEPTH  = 8;
  localparam int CLK_MHZ     = 125;
  localparam int BIT_DIV     = 4;        // System clocks per lane bit
  localparam int DIV_W       = 3;

  // ----------------------------------------------------------------
  // Frame layout per lane: sync high, sync low, balance flag, payload
  // ----------------------------------------------------------------
  localparam int FRAME_W     = 19;
  localparam int CNT_W       = 5;
  localparam int DUAL_BITS   = 16;
  localparam int QUAD_BITS   = 8;
  localparam logic [CNT_W-1:0] DUAL_LEN = 5'h13;
  localparam logic [CNT_W-1:0] QUAD_LEN = 5'h0B;
  localparam logic [1:0]       SYNC_BITS = 2'b10;

  // ----------------------------------------------------------------
  // Scrambler and test pattern seeds
  // ----------------------------------------------------------------
  localparam logic [15:0] SCR_SEED  = 16'hACE1;
  localparam logic [15:0] SCR_TAPS  = 16'hB400;
  localparam logic [31:0] BIST_SEED = 32'h0000_0001;
  localparam logic [31:0] IDLE_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOAD  = 2'b01,
    ST_SHIFT = 2'b10
  } ser_state_type;

  typedef struct packed {
    logic power_up;
    logic quad;
    logic rise;
    logic bist;
  } ctrl_type;

endpackage : lane_ser_pkg

// [core/word_fifo.sv]
/*
  Word FIFO with a registered read stage, valid/ready on both sides.
  Assumes one clock; clear is synchronous and empties the FIFO.
*/
module word_fifo
  import lane_ser_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_clear,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic      [WIDTH-1:0] o_rd_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [PW:0]      cnt_reg,    cnt_next;
  logic             out_vld_reg, out_vld_next;
  logic [WIDTH-1:0] out_reg;
  logic             push, load;

  // ----------------------------------------------------------------
  // Pointer and output-stage control
  // ----------------------------------------------------------------
  assign o_wr_ready = (cnt_reg != DEPTH[PW:0]);
  assign o_rd_valid = out_vld_reg;
  assign o_rd_data  = out_reg;

  // Refill output stage when it is empty or being drained
  always_comb begin
    push         = i_wr_valid && o_wr_ready;
    load         = (cnt_reg != '0) && (!out_vld_reg || i_rd_ready);
    wr_ptr_next  = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next  = load ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    cnt_next     = cnt_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, load};
    out_vld_next = load || (out_vld_reg && !i_rd_ready);
    if (i_clear) begin
      wr_ptr_next  = '0;
      rd_ptr_next  = '0;
      cnt_next     = '0;
      out_vld_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      cnt_reg     <= '0;
      out_vld_reg <= 1'b0;
    end else begin
      wr_ptr_reg  <= wr_ptr_next;
      rd_ptr_reg  <= rd_ptr_next;
      cnt_reg     <= cnt_next;
      out_vld_reg <= out_vld_next;
    end
  end

  // Storage and registered read data
  always_ff @(posedge i_clk) begin
    if (push && !i_clear) begin
      mem[wr_ptr_reg] <= i_wr_data;
    end
    if (load) begin
      out_reg <= mem[rd_ptr_reg];
    end
  end

endmodule : word_fifo

// [core/lane_serializer.sv]
/*
  Serializer core: samples the parallel word on the chosen strobe
  edge, buffers it, scrambles and balance codes it and shifts framed
  bits out on two or four lanes with the clock embedded.
  Assumes I_CLK_SYS is the only clock and every pin is synchronous.
*/
module lane_serializer
  import lane_ser_pkg::*;
#(
  parameter int BIT_DIVIDE = BIT_DIV,
  parameter int BUF_DEPTH  = FIFO_DEPTH
) (
  input  wire logic                I_CLK_SYS,
  input  wire logic                I_RST,
  input  wire logic [WORD_W-1:0]   I_PAR_WORD_IN,
  input  wire logic                I_PAR_CLK_IN,
  input  wire logic                I_POWER_DOWN_N,
  input  wire logic                I_EDGE_SELECT,
  input  wire logic                I_LANE_QUAD,
  input  wire logic                I_SELF_TEST_ENABLE,
  input  wire logic                I_PRE_DISABLE,
  input  wire logic                I_SWING_SELECT,
  input  wire logic                I_RESERVED_TIE_LOW,
  output logic      [LANE_MAX-1:0] O_LANE_OUT,
  output logic      [LANE_MAX-1:0] O_LANE_OE,
  output logic                     O_PLL_RUN,
  output logic                     O_PRE_EMPH_EN,
  output logic                     O_SWING_HIGH,
  output logic                     O_WORD_READY,
  output logic                     O_WORD_DROP,
  output logic                     O_CFG_FAULT
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Advance the scrambler 32 steps, returning {state, key}
  function automatic logic [47:0] scr_step(input logic [15:0] s);
    logic [15:0] st;
    logic [31:0] key;
    st  = s;
    key = '0;
    for (int k = 0; k < WORD_W; k++) begin
      key[k] = st[0];
      st     = st[0] ? ((st >> 1) ^ SCR_TAPS) : (st >> 1);
    end
    return {st, key};
  endfunction : scr_step

  // Balance coding: invert a chunk with too many ones, flag it
  function automatic logic [16:0] balance(input logic [15:0] d,
                                          input logic        quad);
    logic [4:0]  ones;
    logic [4:0]  half;
    logic [15:0] msk;
    ones = '0;
    msk  = quad ? 16'h00FF : 16'hFFFF;
    half = quad ? 5'h04 : 5'h08;
    for (int k = 0; k < DUAL_BITS; k++) begin
      ones = ones + {4'h0, d[k] & msk[k]};
    end
    if (ones > half) begin
      return {1'b1, ~d & msk};
    end
    return {1'b0, d & msk};
  endfunction : balance

  // ----------------------------------------------------------------
  // Control capture and static pin outputs
  // ----------------------------------------------------------------
  ctrl_type ctrl;
  logic     pre_reg,   pre_next;
  logic     swing_reg, swing_next;
  logic     fault_reg, fault_next;

  assign ctrl.power_up = I_POWER_DOWN_N;
  assign ctrl.quad     = I_LANE_QUAD;
  assign ctrl.rise     = I_EDGE_SELECT;
  assign ctrl.bist     = I_SELF_TEST_ENABLE;

  // Pre-emphasis only with a level resistor, never when high/floating
  always_comb begin
    pre_next   = ctrl.power_up && !I_PRE_DISABLE;
    swing_next = I_SWING_SELECT;
    fault_next = I_RESERVED_TIE_LOW;
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      pre_reg   <= 1'b0;
      swing_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      pre_reg   <= pre_next;
      swing_reg <= swing_next;
      fault_reg <= fault_next;
    end
  end

  assign O_PRE_EMPH_EN = pre_reg;
  assign O_SWING_HIGH  = swing_reg;
  assign O_CFG_FAULT   = fault_reg;

  // ----------------------------------------------------------------
  // Strobe edge detection and word capture
  // ----------------------------------------------------------------
  logic              strb_reg,  strb_next;
  logic              drop_reg,  drop_next;
  logic              take;
  logic              wr_ready;
  logic              rd_valid;
  logic              rd_ready;
  logic [WORD_W-1:0] rd_data;

  // Pick rising or falling edge of the sampled strobe
  always_comb begin
    strb_next = I_PAR_CLK_IN;
    take      = 1'b0;
    if (ctrl.power_up && !ctrl.bist) begin
      take = ctrl.rise ? (I_PAR_CLK_IN && !strb_reg)
                       : (!I_PAR_CLK_IN && strb_reg);
    end
    drop_next = take && !wr_ready;
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      strb_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      strb_reg <= strb_next;
      drop_reg <= drop_next;
    end
  end

  assign O_WORD_READY = wr_ready && ctrl.power_up;
  assign O_WORD_DROP  = drop_reg;

  // Buffer between the strobe domain of words and the lane framer
  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_fifo (
    .i_clk      (I_CLK_SYS),
    .i_rst      (I_RST),
    .i_clear    (!ctrl.power_up),
    .i_wr_valid (take),
    .o_wr_ready (wr_ready),
    .i_wr_data  (I_PAR_WORD_IN),
    .o_rd_valid (rd_valid),
    .i_rd_ready (rd_ready),
    .o_rd_data  (rd_data)
  );

  // ----------------------------------------------------------------
  // Lane bit-rate divider
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_reg, div_next;
  logic             bit_en;

  // One-cycle enable per lane bit
  always_comb begin
    bit_en   = (div_reg == DIV_W'(BIT_DIVIDE - 1));
    div_next = bit_en ? '0 : div_reg + 1'b1;
    if (!ctrl.power_up) begin
      div_next = '0;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // ----------------------------------------------------------------
  // Framer: scramble, balance, load and shift the lanes
  // ----------------------------------------------------------------
  ser_state_type     state_reg, state_next;
  logic [15:0]       scr_reg,   scr_next;
  logic [WORD_W-1:0] bist_reg,  bist_next;
  logic              quad_reg,  quad_next;
  logic [CNT_W-1:0]  cnt_reg,   cnt_next;
  logic [FRAME_W-1:0] sh_reg  [LANE_MAX];
  logic [FRAME_W-1:0] sh_next [LANE_MAX];
  logic [LANE_MAX-1:0] oe_reg, oe_next;
  logic              pll_reg,   pll_next;
  logic [WORD_W-1:0] payload;
  logic [WORD_W-1:0] scrambled;
  logic [47:0]       scr_out;
  logic [16:0]       bal;
  logic [15:0]       chunk;
  logic [CNT_W-1:0]  frame_len;

  always_comb begin
    state_next = state_reg;
    scr_next   = scr_reg;
    bist_next  = bist_reg;
    quad_next  = quad_reg;
    cnt_next   = cnt_reg;
    oe_next    = oe_reg;
    pll_next   = 1'b1;
    rd_ready   = 1'b0;
    payload    = IDLE_WORD;
    scrambled  = '0;
    scr_out    = '0;
    bal        = '0;
    chunk      = '0;
    frame_len  = quad_reg ? QUAD_LEN : DUAL_LEN;
    for (int l = 0; l < LANE_MAX; l++) begin
      sh_next[l] = sh_reg[l];
    end
    case (state_reg)
      ST_IDLE: begin
        state_next = ST_LOAD;
      end
      ST_LOAD: begin
        // Test pattern or buffered word; idle word keeps lanes alive
        if (ctrl.bist) begin
          payload   = bist_reg;
          bist_next = {bist_reg[30:0],
                       bist_reg[31] ^ bist_reg[21]
                       ^ bist_reg[1] ^ bist_reg[0]};
        end else if (rd_valid) begin
          payload  = rd_data;
          rd_ready = 1'b1;
        end
        scr_out   = scr_step(scr_reg);
        scr_next  = scr_out[47:32];
        scrambled = payload ^ scr_out[31:0];
        quad_next = ctrl.quad;
        for (int l = 0; l < LANE_MAX; l++) begin
          // Chunk of the word carried by this lane
          if (ctrl.quad) begin
            chunk = {8'h00, scrambled[QUAD_BITS*l +: QUAD_BITS]};
          end else if (l < 2) begin
            chunk = scrambled[DUAL_BITS*l +: DUAL_BITS];
          end else begin
            chunk = '0;
          end
          bal = balance(chunk, ctrl.quad);
          // Sync pair carries the embedded clock edge
          sh_next[l] = ctrl.quad
                     ? {SYNC_BITS, bal[16], bal[7:0], 8'h00}
                     : {SYNC_BITS, bal[16], bal[15:0]};
        end
        oe_next    = ctrl.quad ? 4'hF : 4'h3;
        cnt_next   = '0;
        state_next = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (bit_en) begin
          for (int l = 0; l < LANE_MAX; l++) begin
            sh_next[l] = {sh_reg[l][FRAME_W-2:0], 1'b0};
          end
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == frame_len - 1'b1) begin
            state_next = ST_LOAD;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Power-down parks the lanes and stops the PLL
    if (!ctrl.power_up) begin
      state_next = ST_IDLE;
      scr_next   = SCR_SEED;
      bist_next  = BIST_SEED;
      cnt_next   = '0;
      oe_next    = '0;
      pll_next   = 1'b0;
      for (int l = 0; l < LANE_MAX; l++) begin
        sh_next[l] = '0;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= ST_IDLE;
      scr_reg   <= SCR_SEED;
      bist_reg  <= BIST_SEED;
      quad_reg  <= 1'b0;
      cnt_reg   <= '0;
      oe_reg    <= '0;
      pll_reg   <= 1'b0;
      for (int l = 0; l < LANE_MAX; l++) begin
        sh_reg[l] <= '0;
      end
    end else begin
      state_reg <= state_next;
      scr_reg   <= scr_next;
      bist_reg  <= bist_next;
      quad_reg  <= quad_next;
      cnt_reg   <= cnt_next;
      oe_reg    <= oe_next;
      pll_reg   <= pll_next;
      for (int l = 0; l < LANE_MAX; l++) begin
        sh_reg[l] <= sh_next[l];
      end
    end
  end

  // ----------------------------------------------------------------
  // Lane pins: MSB of each shifter, enable only on active lanes
  // ----------------------------------------------------------------
  for (genvar g = 0; g < LANE_MAX; g++) begin : g_lane
    assign O_LANE_OUT[g] = sh_reg[g][FRAME_W-1];
  end

  assign O_LANE_OE = oe_reg;
  assign O_PLL_RUN = pll_reg;

endmodule : lane_serializer

// [verif/lane_ser_chk_sva.sv]
/*
  Port checker for the lane serializer core.
  Assumes one clock and an active high reset; bound to the core.
*/
module lane_ser_chk
  import lane_ser_pkg::*;
(
  input wire logic                I_CLK_SYS,
  input wire logic                I_RST,
  input wire logic                I_POWER_DOWN_N,
  input wire logic                I_PRE_DISABLE,
  input wire logic                I_SELF_TEST_ENABLE,
  input wire logic                I_RESERVED_TIE_LOW,
  input wire logic [LANE_MAX-1:0] O_LANE_OE,
  input wire logic                O_PLL_RUN,
  input wire logic                O_PRE_EMPH_EN,
  input wire logic                O_WORD_READY,
  input wire logic                O_WORD_DROP,
  input wire logic                O_CFG_FAULT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);

  // Power-down held, and wake-up with power held
  sequence s_off2;
    !I_POWER_DOWN_N [*2];
  endsequence
  sequence s_wake;
    $rose(I_POWER_DOWN_N) ##1 I_POWER_DOWN_N [*4];
  endsequence

  property p_pd_off;
    !I_POWER_DOWN_N |=> O_LANE_OE == 4'h0 && !O_PLL_RUN;
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("lanes driven in power-down");
  property p_ready;
    s_off2 |-> !O_WORD_READY;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready while powered down");
  property p_wake;
    s_wake |-> O_PLL_RUN && O_LANE_OE[0];
  endproperty
  a_wake: assert property (p_wake)
    else $error("lanes not up after power-up");
  property p_shape;
    O_LANE_OE != 4'h0 |->
      O_PLL_RUN && (O_LANE_OE == 4'h3 || O_LANE_OE == 4'hF);
  endproperty
  a_shape: assert property (p_shape)
    else $error("bad lane enable set");
  property p_pre;
    !$past(I_RST) |->
      O_PRE_EMPH_EN == ($past(I_POWER_DOWN_N) && !$past(I_PRE_DISABLE));
  endproperty
  a_pre: assert property (p_pre)
    else $error("pre-emphasis state wrong");
  property p_cfg;
    !$past(I_RST) |-> O_CFG_FAULT == $past(I_RESERVED_TIE_LOW);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("fault flag wrong");
  property p_drop;
    O_WORD_DROP |-> !$past(O_WORD_READY) ##1 !O_WORD_DROP;
  endproperty
  a_drop: assert property (p_drop)
    else $error("drop without full buffer");
  property p_bist;
    I_SELF_TEST_ENABLE |=> !O_WORD_DROP;
  endproperty
  a_bist: assert property (p_bist)
    else $error("word taken in self-test");
endmodule : lane_ser_chk

bind lane_serializer lane_ser_chk u_chk (
  .I_CLK_SYS, .I_RST, .I_POWER_DOWN_N, .I_PRE_DISABLE, .I_SELF_TEST_ENABLE,
  .I_RESERVED_TIE_LOW, .O_LANE_OE, .O_PLL_RUN, .O_PRE_EMPH_EN,
  .O_WORD_READY, .O_WORD_DROP, .O_CFG_FAULT);

// [verif/lane_rx_model.sv]
/*
  Lane receiver model: finds the sync edge on lane 0, samples bits
  mid-cell, undoes balance and scrambling and rebuilds each word.
  Assumes bit cells of BIT_DIVIDE system clocks.
*/
module lane_rx_model
  import lane_ser_pkg::*;
#(
  parameter int BIT_DIVIDE = BIT_DIV
) (
  input  wire logic                i_clk,
  input  wire logic [LANE_MAX-1:0] i_lane,
  input  wire logic [LANE_MAX-1:0] i_oe,
  output logic                     o_lock,
  output logic                     o_valid,
  output logic      [WORD_W-1:0]   o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LANE_MAX-1:0][16:0] sh;
  logic [15:0]               scr;
  logic [15:0]               s;
  logic [WORD_W-1:0]         w;
  logic                      prev, hunt, dec, qd;
  int                        cnt, last;

  // Lock from lane 0 sync only while i_oe[0] is high; o_valid stays low until a word decodes
  always @(posedge i_clk) begin
    prev    <= i_lane[0];
    o_valid <= 1'h0;
    // Sync-low cell comes first, then flag and payload cells
    last = ((qd ? QUAD_BITS : DUAL_BITS) + 1) * BIT_DIVIDE
           + BIT_DIVIDE / 2 - 1;
    if (i_oe[0] !== 1'h1) begin
      scr    <= SCR_SEED;
      hunt   <= 1'h1;
      dec    <= 1'h0;
      o_lock <= 1'h0;
      o_word <= ~o_word;
    end else if (hunt && prev && !i_lane[0]) begin
      hunt <= 1'h0;
      cnt  <= 0;
      qd   <= i_oe[2];
    end else if (!hunt) begin
      cnt <= cnt + 1;
      if (cnt % BIT_DIVIDE == BIT_DIVIDE / 2 - 1 && cnt <= last) begin
        for (int l = 0; l < LANE_MAX; l++)
          sh[l] <= {sh[l][15:0], i_lane[l]};
      end
      if (cnt == last)
        dec <= 1'h1;
      if (cnt == last + 2)
        hunt <= 1'h1;
    end
    // Remove balance inversion and scrambler key
    if (dec && i_oe[0] === 1'h1) begin
      s = scr;
      for (int k = 0; k < WORD_W; k++) begin
        w[k] = s[0];
        s    = (s >> 1) ^ (s[0] ? SCR_TAPS : 16'h0000);
      end
      for (int l = 0; l < LANE_MAX; l++) begin
        if (qd)
          w[8*l+:8] ^= sh[l][8] ? ~sh[l][7:0] : sh[l][7:0];
        else if (l < 2)
          w[16*l+:16] ^= sh[l][16] ? ~sh[l][15:0] : sh[l][15:0];
      end
      scr     <= s;
      o_word  <= w;
      o_valid <= 1'h1;
      o_lock  <= 1'h1;
      dec     <= 1'h0;
    end
  end
endmodule : lane_rx_model

// [verif/tb_top.sv]
/*
  Bench for the lane serializer: strobed word source, lane receiver
  model and directed scenarios.
  Assumes the checker is bound to the core.
*/
module tb_top
  import lane_ser_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, rst, strb, pdn, esel, quad, bist;
  logic                pdis, swg, rsv, pll, pre, swh, rdy;
  logic                drop, cfg, lock, rxv;
  logic [WORD_W-1:0]   word, rxw, got;
  logic [LANE_MAX-1:0] lane, oe;
  int                  failures, cmp_count, drops, busy;

  // Clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  lane_serializer dut (
    .I_CLK_SYS(clk), .I_RST(rst), .I_PAR_WORD_IN(word),
    .I_PAR_CLK_IN(strb), .I_POWER_DOWN_N(pdn), .I_EDGE_SELECT(esel),
    .I_LANE_QUAD(quad), .I_SELF_TEST_ENABLE(bist), .I_PRE_DISABLE(pdis),
    .I_SWING_SELECT(swg), .I_RESERVED_TIE_LOW(rsv), .O_LANE_OUT(lane),
    .O_LANE_OE(oe), .O_PLL_RUN(pll), .O_PRE_EMPH_EN(pre),
    .O_SWING_HIGH(swh), .O_WORD_READY(rdy), .O_WORD_DROP(drop),
    .O_CFG_FAULT(cfg));
  lane_rx_model rx (.i_clk(clk), .i_lane(lane), .i_oe(oe),
    .o_lock(lock), .o_valid(rxv), .o_word(rxw));

  // Drop and busy counters
  always @(posedge clk) begin
    if (drop === 1'h1) drops++;
    if (rdy === 1'h0) busy++;
  end

  task automatic chk(input string n, input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic step(input logic [31:0] w, input logic lv);
    @(posedge clk);
    word <= w;
    strb <= lv;
    // Levels of 3 cycles dual, 1 cycle quad
    repeat (quad ? 0 : 2) @(posedge clk);
  endtask : step

  // First non-idle word from the receiver
  task automatic get();
    got = 32'h0000_0000;
    for (int n = 0; n < 3000 && got === 32'h0000_0000; n++) begin
      @(posedge clk);
      if (rxv === 1'h1) got = rxw;
    end
  endtask : get

  task automatic t_edge(input logic sel, input logic [31:0] a, b);
    esel <= sel;
    step(a, 1'h1);
    step(b, 1'h0);
    get();
    chk("word", got, sel ? a : b);
  endtask : t_edge

  task automatic t_pins();
    for (int i = 0; i < 2; i++) begin
      pdis <= 1'(i);
      swg  <= 1'(i);
      rsv  <= 1'(i);
      repeat (2) @(posedge clk);
      chk("pre", 32'(pre), 32'(i == 0));
      chk("swing", 32'(swh), 32'(i));
      chk("fault", 32'(cfg), 32'(i));
    end
    rsv <= 1'h0;
  endtask : t_pins

  task automatic t_quad();
    quad <= 1'h1;
    repeat (100) @(posedge clk);
    t_edge(1'h1, 32'h8E21_C4B7, 32'h0000_0001);
    chk("quad oe", 32'(oe), 32'h0000_000F);
    quad <= 1'h0;
    repeat (100) @(posedge clk);
    chk("dual oe", 32'(oe), 32'h0000_0003);
  endtask : t_quad

  task automatic t_full();
    drops = 0;
    busy  = 0;
    for (int i = 0; i < 12; i++) begin
      step(32'h1000_0000 + i, 1'h1);
      step(32'h1000_0000 + i, 1'h0);
    end
    chk("drop", 32'(drops > 0), 32'h0000_0001);
    chk("full", 32'(busy > 0), 32'h0000_0001);
    get();
    chk("head", got, 32'h1000_0000);
    repeat (1500) @(posedge clk);
    chk("drained", 32'(rdy), 32'h0000_0001);
  endtask : t_full

  task automatic t_bist();
    drops = 0;
    bist <= 1'h1;
    step(32'h5A5A_F00F, 1'h1);
    step(32'h5A5A_F00F, 1'h0);
    get();
    // First test word is the LFSR seed
    chk("test word", got, BIST_SEED);
    chk("test drop", 32'(drops), 32'h0000_0000);
    bist <= 1'h0;
  endtask : t_bist

  task automatic t_pd();
    pdn <= 1'h0;
    // Receiver drops lock one cycle after the lanes park
    repeat (3) @(posedge clk);
    chk("pd oe", 32'(oe), 32'h0000_0000);
    chk("pd pll", 32'(pll), 32'h0000_0000);
    chk("pd rdy", 32'(rdy), 32'h0000_0000);
    chk("pd pre", 32'(pre), 32'h0000_0000);
    chk("lock", 32'(lock), 32'h0000_0000);
    pdn <= 1'h1;
    repeat (6) @(posedge clk);
    chk("up pll", 32'(pll), 32'h0000_0001);
    t_edge(1'h1, 32'h3C3C_0001, 32'h0000_0002);
  endtask : t_pd

  task automatic end_of_test();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    end_of_test();
  end

  // Main sequence
  initial begin
    {rst, pdn, esel} = 3'h7;
    {strb, quad, bist, pdis, swg, rsv} = 6'h00;
    word = 32'h0000_0000;
    repeat (5) @(posedge clk);
    chk("rst oe", 32'(oe), 32'h0000_0000);
    chk("rst rdy", 32'(rdy), 32'h0000_0001);
    rst <= 1'h0;
    t_pins();
    t_edge(1'h1, 32'hA5C3_0F81, 32'h0000_0003);
    t_edge(1'h0, 32'h0000_0004, 32'hFFFF_0000);
    t_quad();
    t_full();
    t_bist();
    t_pd();
    end_of_test();
  end
endmodule : tb_top
